// ===== logic/wtw_device.sv
`timescale 1ns/10ps
`default_nettype none
`include "wtw_defines.svh"
module wtw_device
	import wtw_pkg::*;
#(
	parameter int UPPER_CYC  = (`WTW_UPPER_US * `WTW_NS_PER_US) / `WTW_CLK_NS,
	parameter int RESET_CYC  = (`WTW_RESET_US * `WTW_NS_PER_US + `WTW_CLK_NS - 1) / `WTW_CLK_NS,
	parameter int THRESH_CYC = (`WTW_THRESH_US * `WTW_NS_PER_US + `WTW_CLK_NS - 1) / `WTW_CLK_NS
)
(
	input  wire logic MCLK_I,
	input  wire logic RST_N_I,
	wtw_if.dev        link,
	output logic      ARMED_O,
	output logic      FAULT_PULSE_O
);
	localparam int CW = `WTW_CNT_W;
	localparam int LOWER_CYC = UPPER_CYC / `WTW_LOWER_RATIO;
	//////////////////////////////////////////////////////////////////
	// Kick synchroniser and edge detect
	logic kick_s1_q;
	logic kick_s2_q;
	logic kick_s3_q;
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			kick_s1_q <= 1'b1;
			kick_s2_q <= 1'b1;
			kick_s3_q <= 1'b1;
		end
		else
		begin
			kick_s1_q <= link.kick_input;
			kick_s2_q <= kick_s1_q;
			kick_s3_q <= kick_s2_q;
		end
	end
	wire fall_edge = kick_s3_q & ~kick_s2_q;
	wire rise_edge = ~kick_s3_q & kick_s2_q;
	wire kick_edge = link.mode_timeout ? (fall_edge | rise_edge) : fall_edge;
	//////////////////////////////////////////////////////////////////
	// State machine
	wtw_state_t    state_q;
	wtw_state_t    state_d;
	logic          flag_n_q;
	logic          flag_n_d;
	logic          load;
	logic [CW-1:0] load_val;
	logic          tmr_done;
	logic [CW-1:0] elapsed_q;
	logic [CW-1:0] elapsed_d;
	logic          fault;
	wire           off        = link.supervision_off_input;
	wire           rst_sys    = ~link.sys_reset_n;
	wire           force_idle = off | rst_sys;
	wire           early      = ~link.mode_timeout && (elapsed_q < CW'(LOWER_CYC));
	wire           early_kick = kick_edge & early;
	wire           late       = tmr_done;
	// Shared timer for delay, threshold and upper boundary
	wtw_down_counter #(.W(CW)) u_tmr
	(
		.MCLK_I  (MCLK_I),
		.RST_N_I (RST_N_I),
		.load_i  (load),
		.value_i (load_val),
		.done_o  (tmr_done),
		.count_o ()
	);
	always_comb
	begin
		state_d  = state_q;
		flag_n_d = flag_n_q;
		load     = 1'b0;
		load_val = CW'(RESET_CYC);
		fault    = 1'b0;
		unique case (state_q)
			WTW_RESET_DLY:
			begin
				// Kicks ignored while the delay runs
				if (tmr_done)
				begin
					flag_n_d = 1'b1;
					state_d  = WTW_THRESH;
					load     = 1'b1;
					load_val = CW'(THRESH_CYC);
				end
			end
			WTW_THRESH:
			begin
				// Threshold crossing; kicks still ignored
				if (tmr_done)
				begin
					state_d  = WTW_FIRST;
					load     = 1'b1;
					load_val = CW'(UPPER_CYC);
				end
			end
			WTW_FIRST:
			begin
				// First kick has no lower bound
				if (late)
				begin
					fault    = 1'b1;
					flag_n_d = 1'b0;
					state_d  = WTW_RESET_DLY;
					load     = 1'b1;
					load_val = CW'(RESET_CYC);
				end
				else if (kick_edge)
				begin
					state_d  = WTW_RUN;
					load     = 1'b1;
					load_val = CW'(UPPER_CYC);
				end
			end
			WTW_RUN:
			begin
				// Window kicks also checked for early
				if (late || early_kick)
				begin
					fault    = 1'b1;
					flag_n_d = 1'b0;
					state_d  = WTW_RESET_DLY;
					load     = 1'b1;
					load_val = CW'(RESET_CYC);
				end
				else if (kick_edge)
				begin
					load     = 1'b1;
					load_val = CW'(UPPER_CYC);
				end
			end
			default:
			begin
				state_d = WTW_RESET_DLY;
				load    = 1'b1;
			end
		endcase
		// Off or system reset restarts from delay
		if (force_idle)
		begin
			state_d  = WTW_RESET_DLY;
			flag_n_d = 1'b1;
			load     = 1'b1;
			load_val = CW'(RESET_CYC);
			fault    = 1'b0;
		end
	end
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
			state_q <= WTW_RESET_DLY;
		else
			state_q <= state_d;
	end
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
			flag_n_q <= 1'b1;
		else
			flag_n_q <= flag_n_d;
	end
	//////////////////////////////////////////////////////////////////
	// Elapsed time since the last accepted kick
	assign elapsed_d = (load || kick_edge) ? '0 : elapsed_q + CW'(1);
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
			elapsed_q <= '0;
		else
			elapsed_q <= elapsed_d;
	end
	//////////////////////////////////////////////////////////////////
	// State decode
	wire armed = (state_q == WTW_FIRST) || (state_q == WTW_RUN);
	//////////////////////////////////////////////////////////////////
	// Outputs
	// One-cycle marker of each fault decision
	logic fault_q;
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
			fault_q <= 1'b0;
		else
			fault_q <= fault;
	end
	// Flag and pulse leave from flip-flops
	assign link.fault_flag_n = flag_n_q;
	assign ARMED_O           = armed;
	assign FAULT_PULSE_O     = fault_q;
endmodule
`default_nettype wire

// ===== logic/wtw_defines.svh
`ifndef WTW_DEFINES_SVH
`define WTW_DEFINES_SVH
// Upper boundary period in microseconds
`define WTW_UPPER_US        17000
// Reset delay in microseconds
`define WTW_RESET_US        25
// Threshold crossing delay in microseconds
`define WTW_THRESH_US       200
// Upper to lower boundary ratio
`define WTW_LOWER_RATIO     31
// Clock period in ns
`define WTW_CLK_NS          10
`define WTW_NS_PER_US       1000
`define WTW_CNT_W           32
`endif

// ===== logic/wtw_pkg.sv
package wtw_pkg;
	typedef enum logic [3:0]
	{
		WTW_RESET_DLY = 4'h1,
		WTW_THRESH    = 4'h2,
		WTW_FIRST     = 4'h4,
		WTW_RUN       = 4'h8
	} wtw_state_t;
endpackage

// ===== logic/wtw_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wtw_if;
	logic kick_input;
	logic mode_timeout;
	logic supervision_off_input;
	logic fault_flag_n;
	logic sys_reset_n;
	modport dev  (input kick_input, mode_timeout, supervision_off_input, sys_reset_n,
		output fault_flag_n);
	modport host (output kick_input, mode_timeout, supervision_off_input, sys_reset_n,
		input fault_flag_n);
endinterface
`default_nettype wire

// ===== logic/wtw_down_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "wtw_defines.svh"
module wtw_down_counter
	import wtw_pkg::*;
#(
	parameter int W = `WTW_CNT_W
)
(
	input  wire logic         MCLK_I,
	input  wire logic         RST_N_I,
	input  wire logic         load_i,
	input  wire logic [W-1:0] value_i,
	output logic              done_o,
	output logic [W-1:0]      count_o
);
	logic [W-1:0] cnt_q;
	wire          zero = (cnt_q == '0);
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
			cnt_q <= '0;
		else if (load_i)
			cnt_q <= value_i;
		else if (!zero)
			cnt_q <= cnt_q - W'(1);
	end
	assign done_o  = zero;
	assign count_o = cnt_q;
endmodule
`default_nettype wire

// ===== logic/wtw_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "wtw_defines.svh"
module wtw_host
	import wtw_pkg::*;
(
	input  wire logic MCLK_I,
	input  wire logic RST_N_I,
	wtw_if.host       link,
	input  wire logic KICK_REQ_I,
	input  wire logic MODE_TIMEOUT_I,
	input  wire logic SUPERVISION_OFF_I,
	input  wire logic SYS_RESET_N_I,
	output logic      FAULT_SEEN_O
);
	logic kick_q;
	logic mode_q;
	logic off_q;
	logic srst_q;
	logic fault_q;
	always_ff @(posedge MCLK_I)
	begin
		if (!RST_N_I)
		begin
			kick_q  <= 1'b1;
			mode_q  <= 1'b0;
			off_q   <= 1'b1;
			srst_q  <= 1'b0;
			fault_q <= 1'b0;
		end
		else
		begin
			kick_q  <= KICK_REQ_I ? ~kick_q : kick_q;
			mode_q  <= MODE_TIMEOUT_I;
			off_q   <= SUPERVISION_OFF_I;
			srst_q  <= SYS_RESET_N_I;
			fault_q <= ~link.fault_flag_n;
		end
	end
	assign link.kick_input            = kick_q;
	assign link.mode_timeout          = mode_q;
	assign link.supervision_off_input = off_q;
	assign link.sys_reset_n           = srst_q;
	assign FAULT_SEEN_O               = fault_q;
endmodule
`default_nettype wire

// ===== test/wtw_checker.sv
`timescale 1ns/10ps
`default_nettype none
module wtw_checker #(parameter int UP = 200, parameter int TH = 10)
(
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic kick_input,
	input wire logic mode_timeout,
	input wire logic supervision_off_input,
	input wire logic sys_reset_n,
	input wire logic fault_flag_n
);
	int hi_q;
	int gap_q;
	always_ff @(posedge MCLK_I)
	begin
		hi_q  <= (!fault_flag_n || !sys_reset_n || supervision_off_input) ? 0 : hi_q + 1;
		gap_q <= $changed(kick_input) ? 0 : gap_q + 1;
	end
	default clocking @(posedge MCLK_I);
	endclocking
	default disable iff (!RST_N_I);
	////////
	sres_flag_a:
		assert property (!sys_reset_n |=> fault_flag_n) else $error("sres");
	off_flag_a:
		assert property (supervision_off_input |=> fault_flag_n) else $error("off");
	low_end_a:
		assert property (disable iff (!RST_N_I || !sys_reset_n)
			$fell(fault_flag_n) |-> ##11 fault_flag_n) else $error("low");
	low_past_a:
		assert property ($rose(fault_flag_n) && $past(sys_reset_n)
			|-> $past(fault_flag_n, 12) && !$past(fault_flag_n, 11)) else $error("past");
	rest_quiet_a:
		assert property ($rose(fault_flag_n) |-> fault_flag_n[*8]) else $error("quiet");
	arm_delay_a:
		assert property ($fell(fault_flag_n) |-> hi_q > TH) else $error("arm");
	tmo_late_a:
		assert property ($fell(fault_flag_n) && mode_timeout |-> gap_q >= UP) else $error("tmo");
	upper_max_a:
		assert property (gap_q < hi_q || hi_q <= TH + UP + 20) else $error("upper");
	cover property ($fell(fault_flag_n) && mode_timeout);
	cover property ($fell(fault_flag_n) && !mode_timeout);
	cover property ($rose(fault_flag_n) && !sys_reset_n);
endmodule
`default_nettype wire

// ===== test/window_timeout_watchdog_tb.sv
`timescale 1ns/10ps
`default_nettype none
module window_timeout_watchdog_tb;
	logic clk = 1'h0, rn = 1'h0, kreq = 1'h0, md = 1'h0, off = 1'h1, srn = 1'h0;
	logic seen, armed, fpls;
	int   n_fail = 0, tests_run = 0;
	wtw_if lnk();
	wtw_device #(.UPPER_CYC(200), .RESET_CYC(10), .THRESH_CYC(10)) i_wtw_device (.MCLK_I(clk),
		.RST_N_I(rn), .link(lnk), .ARMED_O(armed), .FAULT_PULSE_O(fpls));
	wtw_host i_wtw_host (.MCLK_I(clk), .RST_N_I(rn), .link(lnk), .KICK_REQ_I(kreq),
		.MODE_TIMEOUT_I(md), .SUPERVISION_OFF_I(off), .SYS_RESET_N_I(srn), .FAULT_SEEN_O(seen));
	wtw_checker #(.UP(200), .TH(10)) i_wtw_checker (.MCLK_I(clk), .RST_N_I(rn),
		.kick_input(lnk.kick_input), .mode_timeout(lnk.mode_timeout), .sys_reset_n(lnk.sys_reset_n),
		.supervision_off_input(lnk.supervision_off_input), .fault_flag_n(lnk.fault_flag_n));
	initial forever #5 clk = ~clk;
	task chk(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %s exp %b got %b", nm, e, g);
		end
	endtask
	task finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task kick(input int gap);
		kreq = 1'h1;
		@(negedge clk);
		kreq = 1'h0;
		repeat (gap) @(negedge clk);
	endtask
	task wait_sig(input bit pulse, input int lim);
		int i;
		for (i = 0; i < lim && (pulse ? fpls : armed) !== 1'h1; i++)
			@(negedge clk);
		if (i == lim)
		begin
			chk("wait", 1'h1, 1'h0);
			finish_test();
		end
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		{rn, srn, off} = 3'h6;
		wait_sig(0, 100);
		repeat (12) kick(24);
		chk("seen", 1'h0, seen);
		repeat (3) kick(1);
		wait_sig(1, 40);
		$display("end window");
		wait_sig(0, 100);
		wait_sig(1, 300);
		chk("armed", 1'h0, armed);
		md = 1'h1;
		wait_sig(0, 100);
		repeat (4) kick(149);
		repeat (2) kick(1);
		chk("seen", 1'h0, seen);
		$display("end timeout");
		off = 1'h1;
		repeat (300) @(negedge clk);
		chk("armed", 1'h0, armed);
		off = 1'h0;
		wait_sig(0, 100);
		wait_sig(1, 300);
		@(negedge clk);
		chk("seen", 1'h1, seen);
		srn = 1'h0;
		repeat (3) @(negedge clk);
		chk("flag", 1'h1, lnk.fault_flag_n);
		$display("end reset");
		finish_test();
	end
endmodule
`default_nettype wire
